/* File: core/parity_flags.sv */
// Sticky parity error flags of the config status register
`timescale 1ns/1ps
`default_nettype none
module parity_flags (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        perr_en,
  input  wire logic        rx_poison_any,
  input  wire logic        rx_poison_cpl,
  input  wire logic        tx_poison_wr,
  input  wire logic [15:0] clr,
  output var  logic [15:0] status_ff,
  output var  logic        dpe_evt,
  output var  logic        mdpe_evt
);
  import poison_pkg::*;

  logic [15:0] nxt_status;

  // Event decode
  assign dpe_evt  = rx_poison_any;
  assign mdpe_evt = perr_en & (tx_poison_wr | rx_poison_cpl);

  // Set wins over clear; flags hold until a one is written
  always_comb begin
    nxt_status               = status_ff & ~clr;
    nxt_status[STS_DPE_BIT]  = (status_ff[STS_DPE_BIT] & ~clr[STS_DPE_BIT]) | dpe_evt;
    nxt_status[STS_MDPE_BIT] = (status_ff[STS_MDPE_BIT] & ~clr[STS_MDPE_BIT]) | mdpe_evt;
  end

  // Status flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_ff <= STS_RST;
    else          status_ff <= nxt_status;
  end

  property p_dpe_set;
    @(posedge pclk) disable iff (!presetn) rx_poison_any |=> status_ff[STS_DPE_BIT];
  endproperty
  a_dpe_set: assert property (p_dpe_set) else $error("detected parity flag not set");

  property p_mdpe_gated;
    @(posedge pclk) disable iff (!presetn) $rose(status_ff[STS_MDPE_BIT]) |-> $past(perr_en);
  endproperty
  a_mdpe_gated: assert property (p_mdpe_gated) else $error("master parity flag set while disabled");

  property p_mdpe_set;
    @(posedge pclk) disable iff (!presetn) (perr_en && (tx_poison_wr || rx_poison_cpl)) |=> status_ff[STS_MDPE_BIT];
  endproperty
  a_mdpe_set: assert property (p_mdpe_set) else $error("master parity flag missed");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn) status_ff[STS_DPE_BIT] && !clr[STS_DPE_BIT] |=> status_ff[STS_DPE_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("detected parity flag lost");

endmodule : parity_flags
`default_nettype wire

/* File: core/poison_pkg.sv */
// Shared types and constants for the poisoned packet error logging block
package poison_pkg;

  // Packet kinds seen by the transaction layer
  typedef enum logic [2:0] {
    KIND_MEM_RD = 3'h0,
    KIND_MEM_WR = 3'h1,
    KIND_CPL    = 3'h2,
    KIND_CFG_RD = 3'h3,
    KIND_CFG_WR = 3'h4,
    KIND_MSG    = 3'h5
  } tlp_kind_e;

  // One packet beat on any stream of the block
  typedef struct packed {
    logic       vld;
    tlp_kind_e  kind;
    logic       poisoned;  // Header poisoned indicator
    logic [7:0] tag;
    logic [9:0] reg_idx;   // Config dword index for config requests
    logic [31:0] data;
  } tlp_s;

  // Configuration space layout
  localparam logic [9:0]  CFG_CMD_STS_IDX = 10'h001;
  localparam int unsigned STS_DPE_BIT     = 15;
  localparam int unsigned STS_MDPE_BIT    = 8;
  localparam int unsigned CMD_PERR_EN_BIT = 6;
  localparam logic [15:0] CMD_WR_MASK     = 16'h0040;
  localparam logic [15:0] CMD_RST         = 16'h0000;
  localparam logic [15:0] STS_RST         = 16'h0000;

  // APB register offsets
  localparam logic [11:0] OFF_CMD_STS  = 12'h000;
  localparam logic [11:0] OFF_IRQ_STS  = 12'h004;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h008;

  // Interrupt status layout
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_DPE      = 0;
  localparam int unsigned IRQ_MDPE     = 1;
  localparam int unsigned IRQ_CFG_BLK  = 2;
  localparam logic [2:0]  IRQ_STS_RST  = 3'h0;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

endpackage : poison_pkg

/* File: core/poisoned_tlp_error_logging.sv */
// Poisoned packet forwarding, config write blocking and parity error logging
`timescale 1ns/1ps
`default_nettype none
module poisoned_tlp_error_logging (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic              irq,
  input  wire poison_pkg::tlp_s  link_rx,
  output var  poison_pkg::tlp_s  app_rx,
  input  wire poison_pkg::tlp_s  app_tx,
  output var  logic              app_tx_ready,
  output var  poison_pkg::tlp_s  link_tx
);
  import poison_pkg::*;

  // Registered state
  logic [15:0]      command_ff;
  logic [15:0]      status;
  logic [IRQ_W-1:0] irq_sts_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic             irq_ff;
  tlp_s             app_rx_ff;
  tlp_s             link_tx_ff;
  tlp_s             cpl_pend_ff;
  logic             tx_ready_ff;
  logic             cfg_out_ff;

  // Received packet decode
  wire rx_poison     = link_rx.vld & link_rx.poisoned;
  wire rx_is_cfg     = (link_rx.kind == KIND_CFG_WR) | (link_rx.kind == KIND_CFG_RD);
  wire rx_cfg        = link_rx.vld & rx_is_cfg;
  wire rx_cfg_wr     = link_rx.vld & (link_rx.kind == KIND_CFG_WR);
  wire rx_cfg_hit    = link_rx.reg_idx == CFG_CMD_STS_IDX;
  wire cfg_wr_ok     = rx_cfg_wr & ~link_rx.poisoned & rx_cfg_hit;
  wire cfg_wr_blk    = rx_cfg_wr & link_rx.poisoned;
  wire rx_poison_cpl = rx_poison & (link_rx.kind == KIND_CPL);

  // Transmit side decode
  wire tx_take       = app_tx.vld & tx_ready_ff;
  wire tx_poison_wr  = tx_take & app_tx.poisoned & (app_tx.kind == KIND_MEM_WR);

  // APB decode
  wire apb_setup     = psel & ~penable;
  wire apb_done      = psel & penable & pready_ff;
  wire apb_wr        = apb_done & pwrite & ~pslverr_ff;
  wire hit_cmd_sts   = paddr == OFF_CMD_STS;
  wire hit_irq_sts   = paddr == OFF_IRQ_STS;
  wire hit_irq_mask  = paddr == OFF_IRQ_MASK;
  wire addr_ok       = hit_cmd_sts | hit_irq_sts | hit_irq_mask;
  wire apb_cmd_wr    = apb_wr & hit_cmd_sts;
  wire apb_isr_wr    = apb_wr & hit_irq_sts;
  wire apb_msk_wr    = apb_wr & hit_irq_mask;

  // Status clear from either software path, one written ones
  wire [15:0] sts_clr = ({16{cfg_wr_ok}} & link_rx.data[31:16]) |
                        ({16{apb_cmd_wr}} & pwdata[31:16]);

  wire perr_en  = command_ff[CMD_PERR_EN_BIT];
  wire dpe_evt;
  wire mdpe_evt;

  // Parity error status flags
  parity_flags u_flags (
    .pclk          (pclk),
    .presetn       (presetn),
    .perr_en       (perr_en),
    .rx_poison_any (rx_poison),
    .rx_poison_cpl (rx_poison_cpl),
    .tx_poison_wr  (tx_poison_wr),
    .clr           (sts_clr),
    .status_ff     (status),
    .dpe_evt       (dpe_evt),
    .mdpe_evt      (mdpe_evt)
  );

  // Command register next value; poisoned writes never reach it
  wire [15:0] cmd_wdata = cfg_wr_ok ? link_rx.data[15:0] : pwdata[15:0];
  wire        cmd_load  = cfg_wr_ok | apb_cmd_wr;
  wire [15:0] nxt_command = cmd_load ? (cmd_wdata & CMD_WR_MASK) : command_ff;

  // Command register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) command_ff <= CMD_RST;
    else          command_ff <= nxt_command;
  end

  // Interrupt events, set wins over clear
  wire [IRQ_W-1:0] irq_evt = {cfg_wr_blk, mdpe_evt, dpe_evt};
  wire [IRQ_W-1:0] isr_clr = apb_isr_wr ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] nxt_irq_sts  = (irq_sts_ff & ~isr_clr) | irq_evt;
  wire [IRQ_W-1:0] nxt_irq_mask = apb_msk_wr ? pwdata[IRQ_W-1:0] : irq_mask_ff;
  wire             nxt_irq      = |(nxt_irq_sts & nxt_irq_mask);

  // Interrupt status, mask and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_ff  <= IRQ_STS_RST;
      irq_mask_ff <= IRQ_MASK_RST;
      irq_ff      <= 1'b0;
    end else begin
      irq_sts_ff  <= nxt_irq_sts;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff      <= nxt_irq;
    end
  end

  // APB read mux, sampled in the setup cycle
  wire [31:0] cmd_sts_word = {status, command_ff};
  wire [31:0] nxt_prdata =
    ~apb_setup   ? prdata_ff :
    hit_cmd_sts  ? cmd_sts_word :
    hit_irq_sts  ? {{(32-IRQ_W){1'b0}}, irq_sts_ff} :
    hit_irq_mask ? {{(32-IRQ_W){1'b0}}, irq_mask_ff} : 32'h0000_0000;
  wire        nxt_pready  = apb_setup;
  wire        nxt_pslverr = apb_setup ? ~addr_ok : (pslverr_ff & ~apb_done);

  // APB response registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Config completion built from the request; never poisoned
  tlp_s nxt_cpl;
  always_comb begin
    nxt_cpl          = '0;
    nxt_cpl.vld      = rx_cfg;
    nxt_cpl.kind     = KIND_CPL;
    nxt_cpl.poisoned = 1'b0;
    nxt_cpl.tag      = link_rx.tag;
    nxt_cpl.reg_idx  = link_rx.reg_idx;
    nxt_cpl.data     = (link_rx.kind == KIND_CFG_RD && rx_cfg_hit) ? cmd_sts_word : 32'h0000_0000;
  end

  // Non-config packets go to the application, poisoned ones too
  tlp_s nxt_app_rx;
  always_comb begin
    nxt_app_rx     = link_rx;
    nxt_app_rx.vld = link_rx.vld & ~rx_is_cfg;
  end

  // Link transmit mux: pending completion has priority over the application
  tlp_s nxt_link_tx;
  always_comb begin
    if (cpl_pend_ff.vld) begin
      nxt_link_tx = cpl_pend_ff;
    end else begin
      nxt_link_tx     = app_tx;
      nxt_link_tx.vld = tx_take;
    end
  end
  // Application held off one cycle after a config request
  wire nxt_tx_ready = ~rx_cfg;
  wire nxt_cfg_out  = cpl_pend_ff.vld;

  // Packet stream registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_rx_ff   <= '0;
      cpl_pend_ff <= '0;
      link_tx_ff  <= '0;
      tx_ready_ff <= 1'b0;
      cfg_out_ff  <= 1'b0;
    end else begin
      app_rx_ff   <= nxt_app_rx;
      cpl_pend_ff <= nxt_cpl;
      link_tx_ff  <= nxt_link_tx;
      tx_ready_ff <= nxt_tx_ready;
      cfg_out_ff  <= nxt_cfg_out;
    end
  end

  // Outputs straight from flip-flops
  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign irq          = irq_ff;
  assign app_rx       = app_rx_ff;
  assign app_tx_ready = tx_ready_ff;
  assign link_tx      = link_tx_ff;

  // Poisoned packets reach the application
  property p_poison_fwd;
    @(posedge pclk) disable iff (!presetn)
      (link_rx.vld && link_rx.poisoned && !rx_is_cfg) |=> (app_rx.vld && app_rx.poisoned);
  endproperty
  a_poison_fwd: assert property (p_poison_fwd) else $error("poisoned packet not delivered");

  // Poisoned config write leaves command alone
  property p_cfg_block;
    @(posedge pclk) disable iff (!presetn)
      (cfg_wr_blk && !apb_cmd_wr) |=> $stable(command_ff);
  endproperty
  a_cfg_block: assert property (p_cfg_block) else $error("poisoned config write changed command");

  // Completion two cycles on, never poisoned
  property p_cfg_clean;
    @(posedge pclk) disable iff (!presetn) rx_cfg |-> ##2 (cfg_out_ff && link_tx.vld && !link_tx.poisoned);
  endproperty
  a_cfg_clean: assert property (p_cfg_clean) else $error("config completion missing or poisoned");

  // Application packets leave unchanged
  property p_tx_fwd;
    @(posedge pclk) disable iff (!presetn)
      tx_take |=> (link_tx.vld && link_tx.poisoned == $past(app_tx.poisoned) && link_tx.data == $past(app_tx.data));
  endproperty
  a_tx_fwd: assert property (p_tx_fwd) else $error("transmit packet altered");

  // Status and event bit set by hardware alone
  property p_dpe_seen;
    @(posedge pclk) disable iff (!presetn) rx_poison |=> (irq_sts_ff[IRQ_DPE] && status[STS_DPE_BIT]);
  endproperty
  a_dpe_seen: assert property (p_dpe_seen) else $error("status not updated on poisoned receive");

  // Unmapped access refused
  property p_apb_resp;
    @(posedge pclk) disable iff (!presetn) (apb_setup && !addr_ok) |=> (pready && pslverr);
  endproperty
  a_apb_resp: assert property (p_apb_resp) else $error("unmapped access not refused");

  // Clean traffic never raises detected parity
  property p_clean_rx;
    @(posedge pclk) disable iff (!presetn)
      (!rx_poison && !status[STS_DPE_BIT]) |=> !status[STS_DPE_BIT];
  endproperty
  a_clean_rx: assert property (p_clean_rx) else $error("detected parity set without poisoned packet");

  // Poisoned config write keeps master parity flag
  property p_cfg_keep_sts;
    @(posedge pclk) disable iff (!presetn)
      (cfg_wr_blk && !apb_cmd_wr && status[STS_MDPE_BIT]) |=> status[STS_MDPE_BIT];
  endproperty
  a_cfg_keep_sts: assert property (p_cfg_keep_sts) else $error("poisoned config write cleared status");

  // Received packets delivered whole
  property p_app_fwd;
    @(posedge pclk) disable iff (!presetn)
      (link_rx.vld && !rx_is_cfg) |=> (app_rx == $past(link_rx));
  endproperty
  a_app_fwd: assert property (p_app_fwd) else $error("received packet altered on delivery");

  // Pending completion stalls the application
  property p_tx_hold;
    @(posedge pclk) disable iff (!presetn)
      cpl_pend_ff.vld |-> !app_tx_ready;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("application ready during completion slot");

  // Config requests stay inside the block
  property p_cfg_consumed;
    @(posedge pclk) disable iff (!presetn)
      rx_cfg |=> !app_rx.vld;
  endproperty
  a_cfg_consumed: assert property (p_cfg_consumed) else $error("config request passed to application");

  // Ready is a one-cycle pulse
  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("ready held longer than one cycle");

  // Interrupt follows unmasked status
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      irq == |(irq_sts_ff & irq_mask_ff);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  // Main scenarios
  c_poison_rx:  cover property (@(posedge pclk) disable iff (!presetn) rx_poison_cpl && perr_en);
  c_cfg_block:  cover property (@(posedge pclk) disable iff (!presetn) cfg_wr_blk);
  c_tx_poison:  cover property (@(posedge pclk) disable iff (!presetn) tx_poison_wr && perr_en);
  c_irq:        cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_cfg_rd:     cover property (@(posedge pclk) disable iff (!presetn) rx_cfg && link_rx.kind == KIND_CFG_RD);

endmodule : poisoned_tlp_error_logging
`default_nettype wire

/* File: test/link_partner.sv */
// Link partner model: sends packets on link_rx and collects link_tx
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input  wire logic             pclk,
  output var  poison_pkg::tlp_s link_rx,
  input  wire poison_pkg::tlp_s link_tx
);
  import poison_pkg::*;
  tlp_s got[$];

  initial link_rx = '0;

  // One beat per packet; afterwards the lines show the inverse, never the last beat
  task automatic send(input tlp_s p);
    tlp_s q;
    q = tlp_s'(~p);
    q.vld = 1'b0;
    @(posedge pclk);
    link_rx <= p;
    @(posedge pclk);
    link_rx <= q;
  endtask : send

  // Collect completions and forwarded packets
  always @(posedge pclk) begin
    if (link_tx.vld === 1'b1) begin
      got.push_back(link_tx);
    end
  end
endmodule : link_partner
`default_nettype wire

/* File: test/poisoned_tlp_error_logging_tb.sv */
// Self-checking bench for poisoned packet error logging
`timescale 1ns/1ps
`default_nettype none
module poisoned_tlp_error_logging_tb;
  import poison_pkg::*;
  logic        pclk, pready, pslverr, irq, app_tx_ready, err;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  tlp_s        link_rx, app_rx, link_tx, app_tx = '0;
  tlp_s        rxq[$];
  int          mismatches = 0, n_compared = 0, seed = 17, cmd = 0, sts = 0, irqs = 0, irqm = 0, e, i;

  poisoned_tlp_error_logging poisoned_tlp_error_logging_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link_rx(link_rx), .app_rx(app_rx), .app_tx(app_tx),
    .app_tx_ready(app_tx_ready), .link_tx(link_tx));
  link_partner link_partner_i (.pclk(pclk), .link_rx(link_rx), .link_tx(link_tx));

  // Clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Collect packets handed to the application
  always @(posedge pclk) begin
    if (app_rx.vld === 1'b1) begin
      rxq.push_back(app_rx);
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic tmo(input string what);
    mismatches++;
    $display("Error %s expected handshake seen timeout", what);
    report_and_stop();
  endtask : tmo

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) tmo("pready");
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write with model update
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
    if (a == OFF_CMD_STS) begin
      cmd = d & 'h40;
      sts = sts & ~(d >> 16);
    end
    if (a == OFF_IRQ_STS) irqs = irqs & ~d;
    if (a == OFF_IRQ_MASK) irqm = d & 7;
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input int exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp[31:0], rd);
  endtask : rdchk

  task automatic irqchk();
    repeat (2) @(posedge pclk);
    chk("irq", (irqs & irqm) != 0, irq);
  endtask : irqchk

  // Packet from the link, checked against the model, then model updated
  task automatic rx(input tlp_kind_e k, input logic pz, input logic [9:0] idx, input logic [31:0] d);
    tlp_s p, q;
    p = '{1'b1, k, pz, 8'($random(seed)), idx, d};
    link_partner_i.send(p);
    repeat (4) @(posedge pclk);
    if (k == KIND_CFG_RD || k == KIND_CFG_WR) begin
      chk("cpl count", 1, link_partner_i.got.size());
      q = link_partner_i.got.pop_front();
      chk("cpl header", {KIND_CPL, 1'b0, p.tag}, {q.kind, q.poisoned, q.tag});
      if (k == KIND_CFG_RD) chk("cpl data", (idx == CFG_CMD_STS_IDX) ? {sts[15:0], cmd[15:0]} : 32'h0, q.data);
    end else begin
      chk("app_rx count", 1, rxq.size());
      chk("app_rx", p, rxq.pop_front());
    end
    link_partner_i.got.delete();
    rxq.delete();
    if (pz) begin
      sts = sts | 'h8000;
      irqs = irqs | 1;
    end
    if (pz && k == KIND_CPL && cmd != 0) begin
      sts = sts | 'h100;
      irqs = irqs | 2;
    end
    if (pz && k == KIND_CFG_WR) irqs = irqs | 4;
    if (!pz && k == KIND_CFG_WR && idx == CFG_CMD_STS_IDX) begin
      cmd = d & 'h40;
      sts = sts & ~(d >> 16);
    end
  endtask : rx

  // Packet from the application, held until app_tx_ready is sampled high
  task automatic tx(input tlp_kind_e k, input logic pz);
    tlp_s q, r;
    int n;
    q = '{1'b1, k, pz, 8'($random(seed)), 10'($random(seed)), 32'($random(seed))};
    r = tlp_s'(~q);
    r.vld = 1'b0;
    @(posedge pclk);
    app_tx <= q;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) tmo("app_tx_ready");
    end while (app_tx_ready !== 1'b1);
    app_tx <= r;
    repeat (3) @(posedge pclk);
    chk("link_tx count", 1, link_partner_i.got.size());
    chk("link_tx", q, link_partner_i.got.pop_front());
    if (pz && k == KIND_MEM_WR && cmd != 0) begin
      sts = sts | 'h100;
      irqs = irqs | 2;
    end
  endtask : tx

  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_CMD_STS, 0);
    rdchk(OFF_IRQ_STS, 0);
    rdchk(OFF_IRQ_MASK, 0);
    apb(1'b1, 12'h00c, 32'hffffffff);
    chk("pslverr", 1, err);
    chk("unmapped prdata", 0, rd);
    wr(OFF_IRQ_MASK, 7);
    rdchk(OFF_IRQ_MASK, 7);
    for (e = 1; e >= 0; e--) begin
      wr(OFF_CMD_STS, e ? 'hffffffff : 'hffff0000);
      wr(OFF_IRQ_STS, 7);
      rdchk(OFF_CMD_STS, cmd);
      rx(KIND_CPL, 1'b1, 10'h2, 32'($random(seed)));
      tx(KIND_MEM_WR, 1'b1);
      tx(KIND_MEM_RD, 1'b1);
      for (i = 0; i < 12; i++) rx(tlp_kind_e'(i % 6), 1'($random(seed)), 10'h2, 32'($random(seed)));
      rdchk(OFF_CMD_STS, (sts << 16) | cmd);
      rdchk(OFF_IRQ_STS, irqs);
    end
    rx(KIND_CFG_WR, 1'b1, CFG_CMD_STS_IDX, 32'h00000040);
    rx(KIND_CFG_WR, 1'b0, CFG_CMD_STS_IDX, 32'h00000040);
    rx(KIND_CFG_WR, 1'b1, CFG_CMD_STS_IDX, 32'hffff0000);
    rdchk(OFF_CMD_STS, (sts << 16) | cmd);
    rx(KIND_CFG_WR, 1'b0, CFG_CMD_STS_IDX, 32'h80000040);
    rx(KIND_CFG_RD, 1'b0, CFG_CMD_STS_IDX, 32'h0);
    rdchk(OFF_CMD_STS, (sts << 16) | cmd);
    rdchk(OFF_IRQ_STS, irqs);
    irqchk();
    wr(OFF_IRQ_MASK, 0);
    irqchk();
    wr(OFF_IRQ_MASK, 7);
    irqchk();
    wr(OFF_IRQ_STS, 7);
    irqchk();
    report_and_stop();
  end
endmodule : poisoned_tlp_error_logging_tb
`default_nettype wire
